//--- hw/nv_port_host.sv
// Behaviour
// R1: Memory selects, starts access and latches address on chip select fall.
// R2: With row open, low two address bits alone pick another column.
// R3: Seventeen address lines pick one of 128K words.
// R4: One sixteen-bit two-way data bus carries reads and writes.
// R5: Write strobe low starts a write; its rise stores the bus word.
// R6: Each write strobe fall in an open row takes a new column.
// R7: Output gate low lets memory drive the bus once data is valid.
// R8: Output gate high floats every data pin.
// R9: High select enables bits 15..8, low select bits 7..0.
// R10: Steering each access to one lane gives a byte-wide memory.
// R11: Hosts without byte writes keep both byte selects low.
// R12: Sleep request low holds the memory in lowest-power sleep.
// R13: Sleep request stays high through every read or write.
// R14: New row needs a chip select fall or upper address change.
// R15: Reads start on select fall or address change; writes on select/strobe.
// R16: A written word is nonvolatile at once, no polling.
// R17: Chip select high precharges; hold it high the minimum precharge time.
// R18: Memory never drives the bus while write strobe is low.
// R19: Finish accesses before sleep; memory ignores other pins meanwhile.
// R20: After raising sleep request wait the sleep exit delay.
// R21: Host releases the bus whenever it enables memory output.
`timescale 1ns/1ps
`include "nv_port_map.svh"

module nv_port_host #(
    parameter int ACCESS_NS = `NVP_ACCESS_NS,
    parameter int PAGE_NS = `NVP_PAGE_NS,
    parameter int PRECHARGE_NS = `NVP_PRECHARGE_NS,
    parameter int SLEEP_EXIT_NS = `NVP_SLEEP_EXIT_NS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`NVP_ADDR_W-1:0] req_addr,
    input wire logic [`NVP_LANES-1:0] req_lane_en,
    input wire logic [`NVP_DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [`NVP_DATA_W-1:0] rsp_rdata,
    input wire logic sleep_cmd,
    output logic asleep,
    output logic [`NVP_ADDR_W-1:0] word_addr_in,
    output logic chip_sel_n,
    output logic write_strobe_n,
    output logic out_gate_n,
    output logic high_byte_sel_n,
    output logic low_byte_sel_n,
    output logic sleep_req_n,
    input wire logic [`NVP_DATA_W-1:0] data_io_bus_in,
    output logic [`NVP_DATA_W-1:0] data_io_bus_out,
    output logic data_io_bus_oe_n
);

    localparam int AW = `NVP_ADDR_W;
    localparam int DW = `NVP_DATA_W;
    localparam int CW = `NVP_CNT_W;

    function automatic int cyc_of(input int ns);
        int c;
        c = (ns + `NVP_MCLK_NS - 1) / `NVP_MCLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACC_CYC = cyc_of(ACCESS_NS);
    localparam int PAGE_CYC = cyc_of(PAGE_NS);
    localparam int PC_CYC = cyc_of(PRECHARGE_NS);
    localparam int ZZ_CYC = cyc_of(SLEEP_EXIT_NS);

    nv_port_pkg::host_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [1:0] lane_n_ff, nxt_lane_n;
    logic [DW-1:0] wdata_ff, nxt_wdata;
    logic [DW-1:0] dq_out_ff, nxt_dq_out;
    logic [DW-1:0] rdata_ff, nxt_rdata;
    logic ce_n_ff, nxt_ce_n;
    logic we_n_ff, nxt_we_n;
    logic oe_n_ff, nxt_oe_n;
    logic zz_n_ff, nxt_zz_n;
    logic dq_oe_n_ff, nxt_dq_oe_n;
    logic open_ff, nxt_open;
    logic wr_ff, nxt_wr;
    logic go_ff, nxt_go;
    logic rsp_ff, nxt_rsp;
    logic [DW-1:0] sync_data;

    pin_sync #(
        .WIDTH(DW)
    ) u_dq_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pin_in(data_io_bus_in),
        .pin_out(sync_data)
    );

    wire in_idle = (state_ff == nv_port_pkg::ST_IDLE);
    wire cnt_zero = (cnt_ff == '0);
    wire take = req_valid && req_ready;
    wire same_row = open_ff && (req_addr[AW-1:`NVP_COL_W] ==
                                addr_ff[AW-1:`NVP_COL_W]);
    // Row change goes through a chip select rise, never an address swap
    wire need_pre = take && open_ff && !same_row; // R14
    wire start_now = (take && !need_pre) ||
                     (state_ff == nv_port_pkg::ST_PRE && cnt_zero && go_ff);
    wire is_page = in_idle && open_ff;
    wire acc_wr = in_idle ? req_write : wr_ff;
    wire [AW-1:0] acc_addr = in_idle ? req_addr : addr_ff;
    wire [1:0] acc_lane_n = in_idle ? ~req_lane_en : lane_n_ff; // R9 R10 R11
    wire [DW-1:0] acc_wdata = in_idle ? req_wdata : wdata_ff;
    wire [CW-1:0] base_cyc = is_page ? CW'(PAGE_CYC) : CW'(ACC_CYC);
    // Reads also wait for the bus word to clear the synchroniser
    wire [CW-1:0] acc_cyc = acc_wr ? base_cyc :
                            CW'(base_cyc + CW'(`NVP_SYNC_LAT));

    assign req_ready = in_idle && !sleep_cmd; // R13

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_zero ? cnt_ff : CW'(cnt_ff - 1'b1);
        nxt_addr = addr_ff;
        nxt_lane_n = lane_n_ff;
        nxt_wdata = wdata_ff;
        nxt_dq_out = dq_out_ff;
        nxt_rdata = rdata_ff;
        nxt_ce_n = ce_n_ff;
        nxt_we_n = we_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_zz_n = zz_n_ff;
        nxt_dq_oe_n = dq_oe_n_ff;
        nxt_open = open_ff;
        nxt_wr = wr_ff;
        nxt_go = go_ff;
        nxt_rsp = 1'b0;
        unique case (state_ff)
            nv_port_pkg::ST_IDLE: begin
                if (sleep_cmd && open_ff) begin
                    nxt_ce_n = 1'b1; // R17
                    nxt_open = 1'b0;
                    nxt_go = 1'b0;
                    nxt_cnt = CW'(PC_CYC - 1);
                    nxt_state = nv_port_pkg::ST_PRE;
                end else if (sleep_cmd) begin
                    nxt_zz_n = 1'b0; // R12 R19
                    nxt_state = nv_port_pkg::ST_SLEEP;
                end else if (need_pre) begin
                    nxt_ce_n = 1'b1; // R14 R17
                    nxt_open = 1'b0;
                    nxt_go = 1'b1;
                    nxt_addr = req_addr;
                    nxt_lane_n = ~req_lane_en;
                    nxt_wdata = req_wdata;
                    nxt_wr = req_write;
                    nxt_cnt = CW'(PC_CYC - 1);
                    nxt_state = nv_port_pkg::ST_PRE;
                end
            end
            nv_port_pkg::ST_PRE: begin
                if (cnt_zero && !go_ff) begin
                    nxt_state = nv_port_pkg::ST_IDLE;
                end
            end
            nv_port_pkg::ST_ACC: begin
                if (cnt_zero) begin
                    nxt_we_n = 1'b1; // R5
                    nxt_oe_n = 1'b1; // R8
                    // A write keeps the last read word on the user side
                    nxt_rdata = wr_ff ? rdata_ff : sync_data; // R7
                    nxt_state = nv_port_pkg::ST_END;
                end
            end
            nv_port_pkg::ST_END: begin
                // Data held one cycle past the strobe rise
                nxt_dq_oe_n = 1'b1;
                nxt_rsp = 1'b1; // R16
                nxt_state = nv_port_pkg::ST_IDLE;
            end
            nv_port_pkg::ST_SLEEP: begin
                if (!sleep_cmd) begin
                    nxt_zz_n = 1'b1;
                    nxt_cnt = CW'(ZZ_CYC - 1); // R20
                    nxt_state = nv_port_pkg::ST_WAKE;
                end
            end
            nv_port_pkg::ST_WAKE: begin
                if (cnt_zero) begin
                    nxt_state = nv_port_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = nv_port_pkg::ST_IDLE;
            end
        endcase
        if (start_now) begin
            nxt_ce_n = 1'b0; // R1 R15
            nxt_open = 1'b1;
            nxt_go = 1'b0;
            nxt_addr = acc_addr; // R2 R3
            nxt_lane_n = acc_lane_n;
            nxt_wr = acc_wr;
            nxt_cnt = CW'(acc_cyc - 1'b1);
            nxt_state = nv_port_pkg::ST_ACC;
            if (acc_wr) begin
                nxt_we_n = 1'b0; // R5 R6
                nxt_dq_out = acc_wdata; // R4
                nxt_dq_oe_n = 1'b0;
            end else begin
                nxt_oe_n = 1'b0; // R7
                nxt_dq_oe_n = 1'b1; // R21
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= nv_port_pkg::ST_IDLE;
            cnt_ff <= '0;
            addr_ff <= '0;
            lane_n_ff <= 2'h3;
            wdata_ff <= '0;
            dq_out_ff <= '0;
            rdata_ff <= '0;
            {ce_n_ff, we_n_ff, oe_n_ff, zz_n_ff} <= 4'hf;
            dq_oe_n_ff <= 1'b1;
            {open_ff, wr_ff, go_ff, rsp_ff} <= 4'h0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            lane_n_ff <= nxt_lane_n;
            wdata_ff <= nxt_wdata;
            dq_out_ff <= nxt_dq_out;
            rdata_ff <= nxt_rdata;
            {ce_n_ff, we_n_ff, oe_n_ff, zz_n_ff} <=
                {nxt_ce_n, nxt_we_n, nxt_oe_n, nxt_zz_n};
            dq_oe_n_ff <= nxt_dq_oe_n;
            {open_ff, wr_ff, go_ff, rsp_ff} <=
                {nxt_open, nxt_wr, nxt_go, nxt_rsp};
        end
    end

    assign word_addr_in = addr_ff;
    assign chip_sel_n = ce_n_ff;
    assign write_strobe_n = we_n_ff;
    assign out_gate_n = oe_n_ff;
    assign high_byte_sel_n = lane_n_ff[`NVP_HI_LANE];
    assign low_byte_sel_n = lane_n_ff[`NVP_LO_LANE];
    assign sleep_req_n = zz_n_ff;
    assign data_io_bus_out = dq_out_ff;
    assign data_io_bus_oe_n = dq_oe_n_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rdata_ff;
    assign asleep = !zz_n_ff;

    // Checking helpers: cycles chip select has been high, cycles awake
    logic [CW-1:0] hi_cnt_ff;
    logic [CW-1:0] wake_cnt_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt_ff <= '1;
            wake_cnt_ff <= '1;
        end else if (clk_en) begin
            hi_cnt_ff <= !chip_sel_n ? '0 :
                         (&hi_cnt_ff) ? hi_cnt_ff : CW'(hi_cnt_ff + 1'b1);
            wake_cnt_ff <= !sleep_req_n ? '0 :
                           (&wake_cnt_ff) ? wake_cnt_ff :
                           CW'(wake_cnt_ff + 1'b1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_bus_release; // R21
        !out_gate_n |-> data_io_bus_oe_n;
    endproperty
    a_bus_release: assert property (p_bus_release) // R21
        else $error("Host drives bus while memory output enabled");

    property p_gate_in_write; // R18
        !write_strobe_n |-> out_gate_n && !data_io_bus_oe_n;
    endproperty
    a_gate_in_write: assert property (p_gate_in_write) // R18
        else $error("Output gate low or bus floating during write");

    property p_awake_access; // R13
        (!write_strobe_n || !out_gate_n) |-> sleep_req_n;
    endproperty
    a_awake_access: assert property (p_awake_access) // R13
        else $error("Access while sleep requested");

    property p_sleep_quiet; // R19
        !sleep_req_n |-> chip_sel_n && write_strobe_n && out_gate_n;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) // R19
        else $error("Memory selected during sleep");

    property p_precharge; // R17
        $fell(chip_sel_n) |-> hi_cnt_ff >= PC_CYC;
    endproperty
    a_precharge: assert property (p_precharge) // R17
        else $error("Chip select high shorter than precharge");

    property p_wake_delay; // R20
        $fell(chip_sel_n) |-> wake_cnt_ff >= ZZ_CYC;
    endproperty
    a_wake_delay: assert property (p_wake_delay) // R20
        else $error("Access before sleep exit delay");

    property p_row_hold; // R14
        (!chip_sel_n && $past(!chip_sel_n)) |->
            word_addr_in[AW-1:2] == $past(word_addr_in[AW-1:2]);
    endproperty
    a_row_hold: assert property (p_row_hold) // R14
        else $error("Row changed without chip select fall");

    property p_write_data; // R5
        $rose(write_strobe_n) |-> !data_io_bus_oe_n ##1 data_io_bus_oe_n;
    endproperty
    a_write_data: assert property (p_write_data) // R5
        else $error("Write data not held across strobe rise");

    property p_strobe_select; // R15
        $fell(write_strobe_n) |-> !chip_sel_n ##[1:300]
            ($rose(write_strobe_n) && !chip_sel_n && $stable(word_addr_in));
    endproperty
    a_strobe_select: assert property (p_strobe_select) // R15
        else $error("Write strobe outside selected access");

endmodule

//--- hw/nv_port_map.svh
`ifndef NV_PORT_MAP_SVH
`define NV_PORT_MAP_SVH

// Pin field layout
`define NVP_ADDR_W 17
`define NVP_DATA_W 16
`define NVP_COL_W 2
`define NVP_LANES 2
`define NVP_HI_LANE 1
`define NVP_LO_LANE 0

// Timing, in ns, and the controller clock period
`define NVP_MCLK_NS 100
`define NVP_ACCESS_NS 100
`define NVP_PAGE_NS 100
`define NVP_PRECHARGE_NS 100
`define NVP_SLEEP_EXIT_NS 1000

// Cycles from a pin change to the synchroniser output
`define NVP_SYNC_LAT 4
`define NVP_CNT_W 12

`endif

//--- hw/nv_port_pkg.sv
package nv_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_PRE   = 3'h1,
        ST_ACC   = 3'h2,
        ST_END   = 3'h3,
        ST_SLEEP = 3'h4,
        ST_WAKE  = 3'h5
    } host_state_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (clk_en) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A bit only moves once two settled stages agree
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                pin_out[i] <= 1'b0;
            end else if (clk_en && (s2_ff[i] == s3_ff[i])) begin
                pin_out[i] <= s3_ff[i];
            end
        end
    end

endmodule

//--- bench/nv_mem_model.sv
`timescale 1ns/1ps
`include "nv_port_map.svh"

module nv_mem_model #(
    parameter int ACC_NS = 60
) (
    input wire logic [`NVP_ADDR_W-1:0] word_addr_in,
    input wire logic chip_sel_n,
    input wire logic write_strobe_n,
    input wire logic out_gate_n,
    input wire logic high_byte_sel_n,
    input wire logic low_byte_sel_n,
    input wire logic sleep_req_n,
    input wire logic [`NVP_DATA_W-1:0] data_io_bus,
    output logic [`NVP_DATA_W-1:0] mem_dout,
    output logic [1:0] mem_drive
);
    logic [`NVP_DATA_W-1:0] cells [0:131071];
    logic [`NVP_ADDR_W-1:0] lat_addr;
    logic data_ok;
    wire awake = sleep_req_n;
    wire drv = !chip_sel_n && !out_gate_n && write_strobe_n && awake && data_ok;

    initial begin
        lat_addr = '0;
        data_ok = 1'b0;
    end
    // Early addresses may set data_ok early; the host waits longer anyway
    always @(negedge chip_sel_n or word_addr_in) begin
        if (!chip_sel_n && awake) begin
            lat_addr = word_addr_in;
            data_ok = 1'b0;
            data_ok <= #(ACC_NS) 1'b1;
        end
    end
    always @(posedge chip_sel_n) begin
        data_ok = 1'b0;
    end
    always @(negedge write_strobe_n) begin
        if (!chip_sel_n && awake) begin
            lat_addr[1:0] = word_addr_in[1:0];
        end
    end
    always @(posedge write_strobe_n) begin
        if (!chip_sel_n && awake) begin
            if (!high_byte_sel_n) cells[lat_addr][15:8] = data_io_bus[15:8];
            if (!low_byte_sel_n) cells[lat_addr][7:0] = data_io_bus[7:0];
        end
    end
    assign mem_drive = {drv && !high_byte_sel_n, drv && !low_byte_sel_n};
    assign mem_dout = cells[lat_addr];
endmodule

//--- bench/tb_nv_port_host.sv
`timescale 1ns/1ps
`include "nv_port_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_nv_port_host;
    localparam int PC_CYC = 1;
    localparam int ZZ_CYC = 10;
    logic mclk, rst_b, clk_en, req_valid, req_ready, req_write, rsp_valid;
    logic sleep_cmd, asleep, chip_sel_n, write_strobe_n, out_gate_n;
    logic high_byte_sel_n, low_byte_sel_n, sleep_req_n, oe_n;
    logic [`NVP_ADDR_W-1:0] req_addr, word_addr_in;
    logic [1:0] req_lane_en, mem_drive;
    logic [15:0] req_wdata, rsp_rdata, host_out, mem_dout, bus, bus_last, q;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int hi_run = 0;
    int wake_cnt = 1000;
    logic cs_prev = 1'b1;
    logic zz_prev = 1'b1;

    nv_port_host #(.ACCESS_NS(100), .PAGE_NS(100), .PRECHARGE_NS(100),
        .SLEEP_EXIT_NS(1000)) i_dut (.mclk(mclk), .rst_b(rst_b),
        .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr),
        .req_lane_en(req_lane_en), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sleep_cmd(sleep_cmd), .asleep(asleep),
        .word_addr_in(word_addr_in), .chip_sel_n(chip_sel_n),
        .write_strobe_n(write_strobe_n), .out_gate_n(out_gate_n),
        .high_byte_sel_n(high_byte_sel_n), .low_byte_sel_n(low_byte_sel_n),
        .sleep_req_n(sleep_req_n), .data_io_bus_in(bus),
        .data_io_bus_out(host_out), .data_io_bus_oe_n(oe_n));

    nv_mem_model i_mem (.word_addr_in(word_addr_in), .chip_sel_n(chip_sel_n),
        .write_strobe_n(write_strobe_n), .out_gate_n(out_gate_n),
        .high_byte_sel_n(high_byte_sel_n), .low_byte_sel_n(low_byte_sel_n),
        .sleep_req_n(sleep_req_n), .data_io_bus(bus), .mem_dout(mem_dout),
        .mem_drive(mem_drive));

    // A released lane flips, so a stale value never reads as fresh
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            bus[i*8 +: 8] = !oe_n ? host_out[i*8 +: 8] :
                mem_drive[i] ? mem_dout[i*8 +: 8] : ~bus_last[i*8 +: 8];
        end
    end

    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        bus_last <= bus;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    always @(posedge mclk) begin
        if (rst_b) begin
            if (!oe_n && |mem_drive) `CHK("bus_clash", 1'b0, 1'b1);
            if (!chip_sel_n && cs_prev) `CHK("precharge", 1'b1, hi_run >= PC_CYC);
            if (!chip_sel_n && cs_prev) `CHK("wake_gap", 1'b1, wake_cnt >= ZZ_CYC);
            if (!sleep_req_n && zz_prev) `CHK("sleep_entry", 3'b111, {chip_sel_n, write_strobe_n, out_gate_n});
            hi_run = chip_sel_n ? hi_run + 1 : 0;
            wake_cnt = sleep_req_n ? wake_cnt + 1 : 0;
            cs_prev = chip_sel_n;
            zz_prev = sleep_req_n;
        end
    end

    task automatic close_out();
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic access(input logic wr, input logic [16:0] a,
        input logic [1:0] ln, input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_lane_en = ln;
        req_wdata = d;
        while (!req_ready && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        while (!rsp_valid && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("rsp_valid", 1'b1, rsp_valid);
        r = rsp_rdata;
    endtask

    task automatic t_page();
        for (int c = 0; c < 4; c++) access(1'b1, {15'h0005, c[1:0]}, 2'b11, 16'h1a00 + 16'(c), q);
        for (int c = 0; c < 4; c++) begin
            access(1'b0, {15'h0005, c[1:0]}, 2'b11, 16'h0000, q);
            `CHK("page_word", 16'h1a00 + 16'(c), q);
        end
        access(1'b1, 17'h1_ffff, 2'b11, 16'hc3e1, q);
        access(1'b1, 17'h0_0000, 2'b11, 16'h5a96, q);
        access(1'b0, 17'h1_ffff, 2'b11, 16'h0000, q);
        `CHK("top_word", 16'hc3e1, q);
        access(1'b0, 17'h0_0000, 2'b11, 16'h0000, q);
        `CHK("bottom_word", 16'h5a96, q);
    endtask

    task automatic t_lanes();
        access(1'b1, 17'h0_0100, 2'b11, 16'h1234, q);
        access(1'b1, 17'h0_0100, 2'b10, 16'hab00, q);
        access(1'b0, 17'h0_0100, 2'b11, 16'h0000, q);
        `CHK("upper_write", 16'hab34, q);
        access(1'b1, 17'h0_0100, 2'b01, 16'h00cd, q);
        access(1'b0, 17'h0_0100, 2'b10, 16'h0000, q);
        `CHK("upper_read", 8'hab, q[15:8]);
        access(1'b0, 17'h0_0100, 2'b01, 16'h0000, q);
        `CHK("lower_read", 8'hcd, q[7:0]);
    endtask

    task automatic t_sleep();
        int n;
        n = 0;
        sleep_cmd = 1'b1;
        while (!asleep && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("sleep_pin", 1'b0, sleep_req_n);
        `CHK("asleep", 1'b1, asleep);
        `CHK("ready_asleep", 1'b0, req_ready);
        repeat (5) @(posedge mclk);
        #1;
        sleep_cmd = 1'b0;
        n = 0;
        while (!req_ready && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("wake_wait", 1'b1, n >= ZZ_CYC);
        access(1'b0, 17'h0_0100, 2'b11, 16'h0000, q);
        `CHK("kept_word", 16'habcd, q);
    endtask

    task automatic t_freeze();
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 17'h0_0101;
        req_lane_en = 2'b11;
        req_wdata = 16'h6b2d;
        `CHK("freeze_ready", 1'b1, req_ready);
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        clk_en = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        `CHK("frozen_strobe", 1'b0, write_strobe_n);
        `CHK("frozen_rsp", 1'b0, rsp_valid);
        clk_en = 1'b1;
        while (!rsp_valid && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("freeze_done", 1'b1, rsp_valid);
        `CHK("rdata_kept", 16'habcd, rsp_rdata);
        access(1'b0, 17'h0_0101, 2'b11, 16'h0000, q);
        `CHK("freeze_word", 16'h6b2d, q);
    endtask

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_lane_en = 2'b11;
        req_wdata = 16'h0000;
        sleep_cmd = 1'b0;
        bus_last = 16'h0000;
        repeat (16) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        t_page();
        t_lanes();
        t_sleep();
        t_freeze();
        close_out();
    end
endmodule
